// ### osrc_pkg.sv
// osrc_pkg: constants and carriers for retired-op sample capture
package osrc_pkg;

  // ----------------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------------
  localparam int CNT_W  = 16;
  localparam int ADDR_W = 48;

  // ----------------------------------------------------------------------
  // op_sample_branch_data field positions (64-bit view)
  // ----------------------------------------------------------------------
  localparam int TAG_RET_LSB  = 0;
  localparam int COMP_RET_LSB = 16;
  localparam int RET_BIT      = 32;
  localparam int MISP_BIT     = 33;
  localparam int TAKEN_BIT    = 34;
  localparam int RETURN_BIT   = 35;
  localparam int MISP_RET_BIT = 36;
  localparam int RESYNC_BIT   = 37;

  // ----------------------------------------------------------------------
  // reset values and LFSR taps
  // ----------------------------------------------------------------------
  localparam logic [15:0] CNT_RESET  = 16'h0000;
  localparam logic [63:0] DATA_RESET = 64'h0000_0000_0000_0000;
  localparam logic [15:0] LFSR_SEED  = 16'hACE1;
  localparam logic [15:0] LFSR_TAPS  = 16'hB400;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic              is_branch;
    logic              is_return;
    logic              is_resync;
    logic              is_ucode_flow;
    logic              mispredicted;
    logic              taken;
    logic              does_load;
    logic              does_store;
    logic              vaddr_valid;
    logic [ADDR_W-1:0] vaddr;
    logic [ADDR_W-1:0] target;
  } osrc_op_info_t;

  typedef struct packed {
    logic              retired_branch_flag;
    logic              return_op_flag;
    logic              resync_op_flag;
    logic              branch_mispredict_flag;
    logic              branch_taken_flag;
    logic              return_mispredict_flag;
    logic              load_op_flag;
    logic              store_op_flag;
    logic              instr_vaddr_invalid;
    logic [ADDR_W-1:0] parent_instr_vaddr;
    logic [ADDR_W-1:0] branch_target;
    logic [CNT_W-1:0]  tag_to_retire_cycles;
    logic [CNT_W-1:0]  complete_to_retire_cycles;
  } osrc_sample_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_DONE = 3'b100
  } osrc_state_t;

endpackage : osrc_pkg

// ### osrc_sat_counter.sv
// osrc_sat_counter: saturating cycle counter with clear and enable
`timescale 1ns/1ps
`default_nettype none
module osrc_sat_counter #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst,
  // control
  input  wire logic         clear,
  input  wire logic         run,
  // count
  output logic [W-1:0]      count
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } osrc_cnt_state_t;

  osrc_cnt_state_t s_reg;
  osrc_cnt_state_t s_next;

  always_comb begin
    s_next = s_reg;
    if (clear) begin
      s_next.cnt = '0;
    end else if (run && (s_reg.cnt != {W{1'b1}})) begin
      s_next.cnt = s_reg.cnt + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign count = s_reg.cnt;

  AST_SATURATE: assert property (@(posedge ref_clk) disable iff (rst)
    (s_reg.cnt == {W{1'b1}}) && !clear |=> (s_reg.cnt == {W{1'b1}}))
    else $error("counter wrapped past its maximum");

endmodule : osrc_sat_counter
`default_nettype wire

// ### osrc_capture.sv
// osrc_capture: retired-op sample capture, counters and flush handling
//
// Behaviour
// - non-branch, non-return, non-resync op reports all three indicators clear
// - load-operate-store op reports both load and store indicators
// - branch op that reads memory also reports the load indicator
// - capture parent instruction address; invalid bit clear only when address valid
// - all ops of one instruction report the same parent address
// - tag-to-retire counting starts when the tagged op leaves decode
// - tag-to-retire keeps counting through stalls, waits, execution and retire wait
// - completion-to-retire counts from execution finish to retirement
// - both cycle counts are captured for every sample type
// - report only retired tagged ops; flushed tagged ops report nothing
// - a mispredicted branch retires, then kills younger ops and redirects
// - retired-branch indicator set for architectural jumps, calls and returns only
// - mispredict and taken are two independent bits
// - mispredict and taken also reflect microcode control-flow changes
// - mispredict and taken valid for all branches, microcode and returns too
// - return flag only for returns; return-mispredict meaningful only with it
// - a resync op flushes the whole pipeline and sets the resync indicator
// - a resync op is never predicted and always counts as taken
// - branch target held separately; zero means no valid target
// - raise an interrupt when a tagged op retires
// - on flush drop the sample and reload selection count pseudo-randomly
`timescale 1ns/1ps
`default_nettype none
module osrc_capture #(
  parameter int CNT_W  = osrc_pkg::CNT_W,
  parameter int ADDR_W = osrc_pkg::ADDR_W
) (
  // clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    rst,
  // from decode: the op tagged this cycle leaves decode
  input  wire logic                    tag_valid,
  input  wire osrc_pkg::osrc_op_info_t tag_info,
  // from execute
  input  wire logic                    exec_complete,
  input  wire logic                    exec_mispredict,
  input  wire logic                    exec_taken,
  // from retire
  input  wire logic                    retire_tagged,
  input  wire logic                    flush_tagged,
  // software read side
  input  wire logic                    sample_read,
  output osrc_pkg::osrc_sample_t       sample,
  output logic [63:0]                  op_sample_branch_data,
  output logic                         sample_valid,
  output logic                         sample_irq,
  // control actions back to the pipeline
  output logic                         kill_younger,
  output logic                         redirect_front_end,
  output logic                         full_flush,
  output logic                         sel_count_load,
  output logic [15:0]                  sel_count_value
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    osrc_pkg::osrc_state_t  st;
    osrc_pkg::osrc_op_info_t info;
    osrc_pkg::osrc_sample_t  smp;
    logic                    valid;
    logic                    irq;
    logic                    kill;
    logic                    resync_flush;
    logic                    reload;
    logic [15:0]             lfsr;
  } osrc_state_bundle_t;

  osrc_state_bundle_t s_reg;
  osrc_state_bundle_t s_next;

  logic [CNT_W-1:0] t2r_count;
  logic [CNT_W-1:0] c2r_count;
  logic             t2r_clear;
  logic             t2r_run;
  logic             c2r_clear;
  logic             c2r_run;
  logic             in_flight;

  // ----------------------------------------------------------------------
  // cycle counters
  // ----------------------------------------------------------------------
  assign in_flight = (s_reg.st != osrc_pkg::ST_IDLE);
  // counter starts in the decode-exit cycle and runs regardless of stalls
  assign t2r_clear = tag_valid && (s_reg.st == osrc_pkg::ST_IDLE);
  assign t2r_run   = in_flight;
  assign c2r_clear = t2r_clear;
  assign c2r_run   = (s_reg.st == osrc_pkg::ST_DONE);

  osrc_sat_counter #(.W(CNT_W)) u_t2r (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clear   (t2r_clear),
    .run     (t2r_run),
    .count   (t2r_count)
  );

  osrc_sat_counter #(.W(CNT_W)) u_c2r (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clear   (c2r_clear),
    .run     (c2r_run),
    .count   (c2r_count)
  );

  // ----------------------------------------------------------------------
  // sample assembly
  // ----------------------------------------------------------------------
  function automatic osrc_pkg::osrc_sample_t build_sample(
    input osrc_pkg::osrc_op_info_t i,
    input logic [CNT_W-1:0]        t2r,
    input logic [CNT_W-1:0]        c2r
  );
    osrc_pkg::osrc_sample_t r;
    logic any_flow;
    r = '0;
    any_flow = i.is_branch || i.is_ucode_flow || i.is_resync;
    r.retired_branch_flag    = i.is_branch;
    r.return_op_flag         = i.is_branch && i.is_return;
    r.resync_op_flag         = i.is_resync;
    // resync is never predicted and always taken
    r.branch_mispredict_flag = any_flow && i.mispredicted && !i.is_resync;
    r.branch_taken_flag      = any_flow && (i.taken || i.is_resync);
    r.return_mispredict_flag = i.is_branch && i.is_return && i.mispredicted;
    r.load_op_flag           = i.does_load;
    r.store_op_flag          = i.does_store;
    r.parent_instr_vaddr     = i.vaddr;
    r.instr_vaddr_invalid    = !i.vaddr_valid;
    r.branch_target          = any_flow ? i.target : '0;
    r.tag_to_retire_cycles      = t2r;
    r.complete_to_retire_cycles = c2r;
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // control
  // ----------------------------------------------------------------------
  always_comb begin
    s_next              = s_reg;
    s_next.irq          = 1'b0;
    s_next.kill         = 1'b0;
    s_next.resync_flush = 1'b0;
    s_next.reload       = 1'b0;
    s_next.lfsr         = s_reg.lfsr[0] ? ((s_reg.lfsr >> 1) ^ osrc_pkg::LFSR_TAPS) : (s_reg.lfsr >> 1);
    if (sample_read) begin
      s_next.valid = 1'b0;
    end
    unique case (s_reg.st)
      osrc_pkg::ST_IDLE: begin
        if (tag_valid) begin
          s_next.info = tag_info;
          s_next.st   = osrc_pkg::ST_EXEC;
        end
      end
      osrc_pkg::ST_EXEC: begin
        if (flush_tagged) begin
          s_next.st     = osrc_pkg::ST_IDLE;
          s_next.reload = 1'b1;
        end else if (exec_complete) begin
          s_next.info.mispredicted = exec_mispredict;
          s_next.info.taken        = exec_taken;
          s_next.st                = osrc_pkg::ST_DONE;
        end
      end
      osrc_pkg::ST_DONE: begin
        if (flush_tagged) begin
          s_next.st     = osrc_pkg::ST_IDLE;
          s_next.reload = 1'b1;
        end else if (retire_tagged) begin
          // whole sample lands in one cycle; a new capture beats a pending read
          s_next.smp   = build_sample(s_reg.info, t2r_count, c2r_count);
          s_next.valid = 1'b1;
          s_next.irq   = 1'b1;
          s_next.kill  = s_next.smp.branch_mispredict_flag;
          s_next.resync_flush = s_reg.info.is_resync;
          s_next.st    = osrc_pkg::ST_IDLE;
        end
      end
      default: s_next.st = osrc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_reg      <= '0;
      s_reg.st   <= osrc_pkg::ST_IDLE;
      s_reg.lfsr <= osrc_pkg::LFSR_SEED;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign sample             = s_reg.smp;
  assign sample_valid       = s_reg.valid;
  assign sample_irq         = s_reg.irq;
  assign kill_younger       = s_reg.kill;
  assign redirect_front_end = s_reg.kill || s_reg.resync_flush;
  assign full_flush         = s_reg.resync_flush;
  assign sel_count_load     = s_reg.reload;
  assign sel_count_value    = s_reg.lfsr;

  always_comb begin
    op_sample_branch_data = osrc_pkg::DATA_RESET;
    op_sample_branch_data[osrc_pkg::TAG_RET_LSB +: 16]  = 16'(s_reg.smp.tag_to_retire_cycles);
    op_sample_branch_data[osrc_pkg::COMP_RET_LSB +: 16] = 16'(s_reg.smp.complete_to_retire_cycles);
    op_sample_branch_data[osrc_pkg::RET_BIT]      = s_reg.smp.retired_branch_flag;
    op_sample_branch_data[osrc_pkg::MISP_BIT]     = s_reg.smp.branch_mispredict_flag;
    op_sample_branch_data[osrc_pkg::TAKEN_BIT]    = s_reg.smp.branch_taken_flag;
    op_sample_branch_data[osrc_pkg::RETURN_BIT]   = s_reg.smp.return_op_flag;
    op_sample_branch_data[osrc_pkg::MISP_RET_BIT] = s_reg.smp.return_mispredict_flag;
    op_sample_branch_data[osrc_pkg::RESYNC_BIT]   = s_reg.smp.resync_op_flag;
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  AST_UNDIFF: assert property (@(posedge ref_clk) disable iff (rst)
    sample_irq && !s_reg.info.is_branch && !s_reg.info.is_resync
      |-> !sample.retired_branch_flag && !sample.return_op_flag && !sample.resync_op_flag)
    else $error("undifferentiated op reported a flow indicator");

  AST_LDST: assert property (@(posedge ref_clk) disable iff (rst)
    sample_irq && s_reg.info.does_load && s_reg.info.does_store
      |-> sample.load_op_flag && sample.store_op_flag)
    else $error("load-operate-store not reported as both");

  AST_BRLOAD: assert property (@(posedge ref_clk) disable iff (rst)
    sample_irq && s_reg.info.is_branch && s_reg.info.does_load |-> sample.load_op_flag)
    else $error("branch load lost its load flag");

  AST_VADDR: assert property (@(posedge ref_clk) disable iff (rst)
    sample_irq |-> sample.instr_vaddr_invalid == !s_reg.info.vaddr_valid
                   && sample.parent_instr_vaddr == s_reg.info.vaddr)
    else $error("parent address or invalid bit wrong");

  AST_T2R_START: assert property (@(posedge ref_clk) disable iff (rst)
    t2r_clear ##1 (in_flight && !flush_tagged) |=> t2r_count == 1)
    else $error("tag-to-retire did not start at decode exit");

  AST_T2R_GE: assert property (@(posedge ref_clk) disable iff (rst)
    sample_irq |-> sample.tag_to_retire_cycles >= sample.complete_to_retire_cycles)
    else $error("tag-to-retire shorter than completion-to-retire");

  AST_NO_FLUSH_REPORT: assert property (@(posedge ref_clk) disable iff (rst)
    in_flight && flush_tagged |=> !sample_irq)
    else $error("flushed op produced a sample");

  AST_RESYNC: assert property (@(posedge ref_clk) disable iff (rst)
    sample_irq && sample.resync_op_flag |-> sample.branch_taken_flag && !sample.branch_mispredict_flag)
    else $error("resync not reported as taken and unpredicted");

  AST_RET_ONLY_BR: assert property (@(posedge ref_clk) disable iff (rst)
    sample.return_op_flag |-> sample.retired_branch_flag)
    else $error("return flag without branch flag");

  AST_IRQ: assert property (@(posedge ref_clk) disable iff (rst)
    s_reg.st == osrc_pkg::ST_DONE && retire_tagged && !flush_tagged |=> sample_irq && sample_valid)
    else $error("retirement did not raise the interrupt");

  AST_KILL: assert property (@(posedge ref_clk) disable iff (rst)
    sample_irq && sample.branch_mispredict_flag |-> kill_younger && redirect_front_end)
    else $error("mispredicted branch did not kill and redirect");

  AST_RELOAD: assert property (@(posedge ref_clk) disable iff (rst)
    in_flight && flush_tagged |=> sel_count_load && s_reg.st == osrc_pkg::ST_IDLE)
    else $error("flush did not reload selection count");

  AST_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
    !sample_irq |-> $stable(sample))
    else $error("sample changed outside retirement");

  AST_BRANCH: assert property (@(posedge ref_clk) disable iff (rst)
    sample_irq |-> sample.retired_branch_flag == s_reg.info.is_branch)
    else $error("wrong branch flag");

  AST_FLOW_BITS: assert property (@(posedge ref_clk) disable iff (rst)
    sample_irq && (s_reg.info.is_branch || s_reg.info.is_ucode_flow) && !s_reg.info.is_resync
      |-> sample.branch_mispredict_flag == s_reg.info.mispredicted
          && sample.branch_taken_flag == s_reg.info.taken)
    else $error("flow bits wrong");

  AST_RET_MISP: assert property (@(posedge ref_clk) disable iff (rst)
    sample_irq |-> sample.return_mispredict_flag
                   == (sample.return_op_flag && s_reg.info.mispredicted))
    else $error("return misp wrong");

  AST_RESYNC_FLUSH: assert property (@(posedge ref_clk) disable iff (rst)
    sample_irq && sample.resync_op_flag |-> full_flush && redirect_front_end)
    else $error("resync did not flush");

  AST_TARGET_ZERO: assert property (@(posedge ref_clk) disable iff (rst)
    sample_irq && !s_reg.info.is_branch && !s_reg.info.is_ucode_flow && !s_reg.info.is_resync
      |-> sample.branch_target == '0)
    else $error("target not zero");

  AST_C2R_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
    s_reg.st == osrc_pkg::ST_EXEC |-> c2r_count == '0)
    else $error("c2r ran early");

  AST_C2R_RUN: assert property (@(posedge ref_clk) disable iff (rst)
    s_reg.st == osrc_pkg::ST_DONE |=> c2r_count != '0)
    else $error("c2r did not run");

  AST_T2R_RUN: assert property (@(posedge ref_clk) disable iff (rst)
    in_flight && t2r_count != {CNT_W{1'b1}} |=> t2r_count == $past(t2r_count) + 1'b1)
    else $error("tag count stalled");

  AST_COUNTS: assert property (@(posedge ref_clk) disable iff (rst)
    sample_irq |-> sample.tag_to_retire_cycles == $past(t2r_count)
                   && sample.complete_to_retire_cycles == $past(c2r_count))
    else $error("counts not captured");

  AST_READ_CLR: assert property (@(posedge ref_clk) disable iff (rst)
    sample_read && !retire_tagged |=> !sample_valid)
    else $error("read did not clear");

  AST_RELOAD_SRC: assert property (@(posedge ref_clk) disable iff (rst)
    sel_count_load |-> $past(flush_tagged))
    else $error("reload without flush");

  AST_KILL_SRC: assert property (@(posedge ref_clk) disable iff (rst)
    kill_younger |-> sample_irq && sample.branch_mispredict_flag)
    else $error("stray kill");

  COV_BRANCH: cover property (@(posedge ref_clk) disable iff (rst)
    sample_irq && sample.retired_branch_flag && sample.branch_mispredict_flag);
  COV_RESYNC: cover property (@(posedge ref_clk) disable iff (rst)
    sample_irq && sample.resync_op_flag);
  COV_FLUSH: cover property (@(posedge ref_clk) disable iff (rst) sel_count_load);
  COV_UNDIFF: cover property (@(posedge ref_clk) disable iff (rst)
    sample_irq && !sample.retired_branch_flag && !sample.resync_op_flag);

endmodule : osrc_capture
`default_nettype wire

// ### osrc_pipe_model.sv
// osrc_pipe_model: behavioural decode, execute and retire stages around the capture block
`timescale 1ns/1ps
`default_nettype none
module osrc_pipe_model (
  // clock
  input  wire logic                   ref_clk,
  // pipeline strobes toward the capture block
  output var logic                    tag_valid,
  output var osrc_pkg::osrc_op_info_t tag_info,
  output var logic                    exec_complete,
  output var logic                    exec_mispredict,
  output var logic                    exec_taken,
  output var logic                    retire_tagged,
  output var logic                    flush_tagged
);
  initial begin
    tag_valid       = 1'b0;
    tag_info        = '0;
    exec_complete   = 1'b0;
    exec_mispredict = 1'b0;
    exec_taken      = 1'b0;
    retire_tagged   = 1'b0;
    flush_tagged    = 1'b0;
  end

  // ----------------------------------------------------------------------
  // one op: tag, complete de cycles later, retire or flush dr cycles after
  // ----------------------------------------------------------------------
  // bad[0] re-tags in flight, bad[1] retires before completion (needs de >= 2)
  // idle qualifiers toggle so a stale value is never mistaken for a live one
  task automatic run_op(input osrc_pkg::osrc_op_info_t info, input logic m, input logic t,
                        input int de, input int dr, input logic fl, input logic [1:0] bad);
    for (int k = 0; k <= de + dr; k++) begin
      @(posedge ref_clk);
      tag_valid       <= (k == 0) || (k == 1 && bad[0]);
      tag_info        <= (k == 0) ? info : ~tag_info;
      exec_complete   <= (k == de);
      exec_mispredict <= (k == de) ? m : ~exec_mispredict;
      exec_taken      <= (k == de) ? t : ~exec_taken;
      retire_tagged   <= (k == de + dr && !fl) || (k == 1 && bad[1]);
      flush_tagged    <= (k == de + dr && fl);
    end
    @(posedge ref_clk);
    tag_valid     <= 1'b0;
    exec_complete <= 1'b0;
    retire_tagged <= 1'b0;
    flush_tagged  <= 1'b0;
  endtask
endmodule // osrc_pipe_model
`default_nettype wire

// ### op_sample_retire_capture_bench.sv
// op_sample_retire_capture_bench: self-checking bench for the retired-op sample capture
`timescale 1ns/1ps
`default_nettype none
module op_sample_retire_capture_bench;
  typedef struct packed {
    osrc_pkg::osrc_sample_t s;
    logic [63:0]            d;
    logic [2:0]             c;
  } osrc_exp_t;

  logic                    ref_clk, rst, sample_read;
  logic                    tag_valid, exec_complete, exec_mispredict, exec_taken, retire_tagged, flush_tagged;
  osrc_pkg::osrc_op_info_t tag_info, info;
  osrc_pkg::osrc_sample_t  sample;
  logic [63:0]             op_sample_branch_data;
  logic                    sample_valid, sample_irq, kill_younger, redirect_front_end, full_flush, sel_count_load;
  logic [15:0]             sel_count_value, load_val, first_val;
  osrc_exp_t               exp_q[$];
  osrc_exp_t               last_exp;
  int                      miscompares, samples_checked, loads_seen, n;
  logic [31:0]             rng, r;
  logic                    flow;

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  osrc_capture i_dut (.ref_clk(ref_clk), .rst(rst), .tag_valid(tag_valid), .tag_info(tag_info),
    .exec_complete(exec_complete), .exec_mispredict(exec_mispredict), .exec_taken(exec_taken),
    .retire_tagged(retire_tagged), .flush_tagged(flush_tagged), .sample_read(sample_read), .sample(sample),
    .op_sample_branch_data(op_sample_branch_data), .sample_valid(sample_valid), .sample_irq(sample_irq),
    .kill_younger(kill_younger), .redirect_front_end(redirect_front_end), .full_flush(full_flush),
    .sel_count_load(sel_count_load), .sel_count_value(sel_count_value));

  osrc_pipe_model i_pipe (.ref_clk(ref_clk), .tag_valid(tag_valid), .tag_info(tag_info),
    .exec_complete(exec_complete), .exec_mispredict(exec_mispredict), .exec_taken(exec_taken),
    .retire_tagged(retire_tagged), .flush_tagged(flush_tagged));

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  task automatic check(input logic [255:0] seen, input logic [255:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("counts: samples_checked=%0d miscompares=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  function automatic osrc_pkg::osrc_op_info_t rand_info(input int k);
    osrc_pkg::osrc_op_info_t i;
    logic [31:0]             v;
    v = xs();
    i = '0;
    i.is_branch     = (k == 1 || k == 2);
    i.is_return     = (k == 2);
    i.is_resync     = (k == 3);
    i.is_ucode_flow = (k == 4);
    {i.does_load, i.does_store, i.vaddr_valid, i.mispredicted, i.taken} = v[4:0];
    i.vaddr  = {v[31:16], xs()};
    i.target = (k >= 1 && k <= 3) ? {v[15:0], xs()} : '0;
    return i;
  endfunction

  function automatic osrc_exp_t model_of(input osrc_pkg::osrc_op_info_t i, input logic m, input logic t,
                                         input int de, input int dr);
    osrc_exp_t e;
    logic      fl, mi;
    fl = i.is_branch | i.is_ucode_flow | i.is_resync;
    mi = fl & ~i.is_resync & m;
    e = '0;
    e.s.retired_branch_flag       = i.is_branch;
    e.s.return_op_flag            = i.is_branch & i.is_return;
    e.s.resync_op_flag            = i.is_resync;
    e.s.branch_mispredict_flag    = mi;
    e.s.branch_taken_flag         = i.is_resync | (fl & t);
    e.s.return_mispredict_flag    = i.is_branch & i.is_return & mi;
    e.s.load_op_flag              = i.does_load;
    e.s.store_op_flag             = i.does_store;
    e.s.instr_vaddr_invalid       = ~i.vaddr_valid;
    e.s.parent_instr_vaddr        = i.vaddr;
    e.s.branch_target             = fl ? i.target : '0;
    e.s.tag_to_retire_cycles      = (de + dr - 1 > 65535) ? 16'hFFFF : 16'(de + dr - 1);
    e.s.complete_to_retire_cycles = (dr - 1 > 65535) ? 16'hFFFF : 16'(dr - 1);
    e.d[31:0] = {e.s.complete_to_retire_cycles, e.s.tag_to_retire_cycles};
    e.d[osrc_pkg::RET_BIT]      = e.s.retired_branch_flag;
    e.d[osrc_pkg::MISP_BIT]     = e.s.branch_mispredict_flag;
    e.d[osrc_pkg::TAKEN_BIT]    = e.s.branch_taken_flag;
    e.d[osrc_pkg::RETURN_BIT]   = e.s.return_op_flag;
    e.d[osrc_pkg::MISP_RET_BIT] = e.s.return_mispredict_flag;
    e.d[osrc_pkg::RESYNC_BIT]   = e.s.resync_op_flag;
    e.c = {mi, i.is_resync, mi | i.is_resync};
    return e;
  endfunction

  // a flushed op queues nothing, so any sample for it shows as unexpected
  task automatic run(input osrc_pkg::osrc_op_info_t i, input logic m, input logic t, input int de,
                     input int dr, input logic fl, input logic [1:0] bad);
    if (!fl) exp_q.push_back(model_of(i, m, t, de, dr));
    i_pipe.run_op(i, m, t, de, dr, fl, bad);
    for (int k = 0; k < 20 && exp_q.size() > 0; k++) @(posedge ref_clk);
    if (exp_q.size() > 0) begin
      miscompares++;
      end_of_test();
    end
    repeat (2) @(posedge ref_clk);
  endtask

  // ----------------------------------------------------------------------
  // output watcher
  // ----------------------------------------------------------------------
  always @(negedge ref_clk) begin
    if (sample_irq === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(sample_irq, 1'b0);
      end else begin
        last_exp = exp_q.pop_front();
        check({sample, op_sample_branch_data, kill_younger, full_flush, redirect_front_end}, last_exp);
        check(sample_valid, 1'b1);
      end
    end
    if (sel_count_load === 1'b1) begin
      loads_seen++;
      load_val = sel_count_value;
    end
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    rng = 32'h1ea0;
    rst = 1'b1;
    sample_read = 1'b0;
    miscompares = 0;
    samples_checked = 0;
    loads_seen = 0;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
    check({op_sample_branch_data, sample_valid, sel_count_value}, {osrc_pkg::DATA_RESET, 1'b0, osrc_pkg::LFSR_SEED});
    $display("test reset done");
    for (int i = 0; i < 8; i++) run(rand_info(i < 4 ? 1 : 2), i[0], i[1], 1 + i % 3, 1 + i / 2, 1'b0, 2'b00);
    $display("test branch_outcomes done");
    for (int i = 0; i < 40; i++) begin
      r = xs();
      info = rand_info(int'(r[2:0]) % 5);
      flow = info.is_branch | info.is_ucode_flow | info.is_resync;
      run(info, flow & r[8], flow & r[9], 1 + int'(r[5:4]), 1 + int'(r[7:6]), 1'b0, 2'b00);
    end
    $display("test random_ops done");
    @(posedge ref_clk);
    sample_read <= 1'b1;
    @(posedge ref_clk);
    sample_read <= 1'b0;
    @(negedge ref_clk);
    check({sample_valid, sample}, {1'b0, last_exp.s});
    $display("test read_clear done");
    run(rand_info(1), 1'b1, 1'b0, 4, 3, 1'b0, 2'b11);
    $display("test refused_requests done");
    n = loads_seen;
    run(rand_info(2), 1'b1, 1'b1, 3, 2, 1'b1, 2'b00);
    first_val = load_val;
    run(rand_info(0), 1'b0, 1'b0, 1, 1, 1'b1, 2'b00);
    check(loads_seen, n + 2);
    check(load_val != first_val, 1'b1);
    check(sample, last_exp.s);
    $display("test flush_drop done");
    run(rand_info(0), 1'b0, 1'b0, 2, 66000, 1'b0, 2'b00);
    $display("test saturation done");
    end_of_test();
  end
endmodule // op_sample_retire_capture_bench
`default_nettype wire
